// ### rtl/pftm_trace.sv
// program flow trace message generator with its output fifo
// Notes on behaviour
// - indirect branch message with count and target
// - sync message on trace start or lost sync
// - branch-with-sync replaces plain sync on branches
// - counter overflow emits resource-full message with count
// - correlation on trace off, debug, sleep entry
// - only executed instructions traced, no corrections
// - silent in debug mode, sync after leaving
// - count bytes: compact two, extended four
// - taken indirect excluded, untaken indirect counted
// - speculative fetches never counted before execution
// - counter cleared on trace messages but plain sync and resource-full, which restart it at the current instruction
// - unique address is xor with last sent
// - full address carries complete target address
// - debug entry correlation uses event code zero
// - branch on debug exit sends branch-with-sync
// - breakpoint on first instruction: correlation code zero
// - direct branch: count and type code three
// - target trace enable: unique address, code 57
// - indirect: address, count, cause, code four
// - cause codes: exception, call, register, return
// - link moves and pc pops are returns
// - sync: full pc, count, code nine
// - direct-with-sync: full target, count, code eleven
// - indirect-with-sync: target, count, cause, code twelve
`timescale 1ns/1ps

module pftm_fifo #(
  parameter int unsigned WIDTH = 56,
  parameter int unsigned DEPTH = pftm_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } pftm_fifo_st_t;

  pftm_fifo_st_t s;
  pftm_fifo_st_t next_s;
  logic          push;
  logic          pop;

  // pointer step with a wrap at the last slot, so depth need not be a power of two
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready  = (s.cnt != FULL);
  assign o_out_valid = s.ov;
  assign o_out_data  = s.od;

  always_comb begin
    next_s = s;
    push   = i_in_valid && (s.cnt != FULL);
    // refill the output register whenever it is empty or being taken
    pop    = (s.cnt != '0) && (!s.ov || i_out_ready);
    if (s.ov && i_out_ready) begin
      next_s.ov = 1'b0;
    end
    if (pop) begin
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = step(s.rp);
    end
    if (push) begin
      next_s.mem[s.wp] = i_in_data;
      next_s.wp        = step(s.wp);
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

module pftm_trace #(
  parameter int unsigned FIFO_DEPTH = pftm_pkg::FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_trace_mode_en,
  input  wire logic        i_target_address_trace_enable,
  input  wire logic        i_debug_mode,
  input  wire logic        i_sleep_mode,
  input  wire logic        i_sync_req,
  input  wire logic        i_bkpt_hit,
  input  wire logic        i_ret_valid,
  input  wire logic        i_ret_ext,
  input  wire logic [1:0]  i_ret_kind,
  input  wire logic [1:0]  i_ret_cause,
  input  wire logic [31:0] i_ret_pc,
  input  wire logic [31:0] i_ret_target,
  output logic             o_stall,
  output logic             o_msg_valid,
  input  wire logic        i_msg_ready,
  output logic [5:0]       o_msg_tcode,
  output logic [31:0]      o_msg_addr,
  output logic [5:0]       o_msg_addr_bits,
  output logic [7:0]       o_msg_cnt,
  output logic [3:0]       o_msg_evt
);

  localparam int unsigned MSG_W = $bits(pftm_pkg::pftm_msg_t);

  typedef struct packed {
    logic                                          dbg_q;
    logic                                          trc_q;
    logic                                          slp_q;
    logic                                          sync_pend;
    logic                                          first_after_dbg;
    logic [7:0]                                    cnt;
    logic [31:0]                                   last_addr;
    logic [7:0]                                    nosync;
    logic [pftm_pkg::PEND_DEPTH-1:0][MSG_W-1:0]    pend;
    logic [1:0]                                    pend_cnt;
    logic                                          stall;
  } pftm_st_t;

  // sync is owed from reset onward
  localparam pftm_st_t ST_RST = '{
    sync_pend: 1'b1,
    default:   '0
  };

  pftm_st_t             s;
  pftm_st_t             next_s;
  pftm_pkg::pftm_msg_t  nm [pftm_pkg::PEND_DEPTH];
  logic [2:0]           nv;
  pftm_pkg::pftm_msg_t  fifo_msg;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [MSG_W-1:0]     fifo_out_data;
  logic                 act;
  logic                 take;
  logic                 is_dir;
  logic                 is_ind;
  logic                 sync_set;
  logic [8:0]           sz;
  logic [8:0]           add;
  logic [8:0]           sum;
  logic [7:0]           base;
  logic [3:0]           evc;
  logic                 corr;

  // count of significant bits once leading zeros are stripped
  function automatic logic [5:0] sig_bits(input logic [31:0] a);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < pftm_pkg::ADDR_W; i++) begin
      if (a[i]) begin
        r = 6'(i + 1);
      end
    end
    return r;
  endfunction

  function automatic pftm_pkg::pftm_msg_t mk(input logic [5:0]  tc,
                                             input logic [31:0] ad,
                                             input logic [7:0]  ct,
                                             input logic [3:0]  ev);
    pftm_pkg::pftm_msg_t m;
    m.tcode = tc;
    m.addr  = ad;
    m.abits = sig_bits(ad);
    m.cnt   = ct;
    m.evt   = ev;
    return m;
  endfunction

  // edges of a level against its copy from the last unstalled cycle
  function automatic logic rose(input logic now, input logic was);
    return now && !was;
  endfunction

  function automatic logic fell(input logic now, input logic was);
    return !now && was;
  endfunction

  // the cause is two bits wide, zero-extended into the event slot
  function automatic logic [3:0] cause_evt(input logic [1:0] c);
    return {2'b00, c};
  endfunction

  always_comb begin
    next_s = s;
    nv     = '0;
    for (int i = 0; i < pftm_pkg::PEND_DEPTH; i++) begin
      nm[i] = '0;
    end
    act    = i_trace_mode_en && !i_debug_mode;
    // retirements offered while stalled are not accepted
    take   = i_ret_valid && !s.stall && act;
    is_dir = (i_ret_kind == pftm_pkg::PFTM_KIND_DIRECT);
    is_ind = (i_ret_kind == pftm_pkg::PFTM_KIND_INDIRECT);
    sz     = i_ret_ext ? pftm_pkg::SIZE_EXTENDED : pftm_pkg::SIZE_COMPACT;
    add    = is_ind ? 9'h000 : sz;
    base   = s.cnt;
    sum    = '0;
    evc    = pftm_pkg::EVC_DEBUG;
    corr   = 1'b0;

    // the branch limit stops asking once a sync is owed, else it re-arms after the sync
    sync_set = rose(i_trace_mode_en, s.trc_q)
            || fell(i_debug_mode, s.dbg_q)
            || fell(i_sleep_mode, s.slp_q)
            || i_sync_req
            || (s.nosync == pftm_pkg::NOSYNC_LIMIT && !s.sync_pend);

    // drain the head of the pending list into the fifo
    if (s.pend_cnt != '0 && fifo_in_ready) begin
      for (int i = 0; i < pftm_pkg::PEND_DEPTH - 1; i++) begin
        next_s.pend[i] = s.pend[i+1];
      end
      next_s.pend_cnt = s.pend_cnt - 1'b1;
    end

    if (take) begin
      next_s.first_after_dbg = 1'b0;
      if ({1'b0, s.cnt} + add > pftm_pkg::CNT_MAX) begin
        nv[0] = 1'b1;
        nm[0] = mk(pftm_pkg::TC_RES_FULL, '0, s.cnt, pftm_pkg::RCODE_COUNTER);
        base  = '0;
      end
      sum        = {1'b0, base} + add;
      next_s.cnt = sum[7:0];
      if (s.sync_pend) begin
        nv[1]         = 1'b1;
        next_s.nosync = '0;
        next_s.cnt    = '0;
        if (is_dir) begin
          nm[1] = mk(pftm_pkg::TC_DIR_SYNC, i_ret_target, sum[7:0], '0);
          next_s.last_addr = i_ret_target;
        end else if (is_ind) begin
          nm[1] = mk(pftm_pkg::TC_IND_SYNC, i_ret_target, sum[7:0],
                     cause_evt(i_ret_cause));
          next_s.last_addr = i_ret_target;
        end else begin
          // the syncing instruction itself starts the next count
          nm[1] = mk(pftm_pkg::TC_SYNC, i_ret_pc, base, '0);
          next_s.cnt       = sz[7:0];
          next_s.last_addr = i_ret_pc;
        end
      end else if (is_dir) begin
        nv[1]         = 1'b1;
        next_s.cnt    = '0;
        next_s.nosync = s.nosync + 1'b1;
        if (i_target_address_trace_enable) begin
          nm[1] = mk(pftm_pkg::TC_DIR_TARGET, i_ret_target ^ s.last_addr,
                     sum[7:0], '0);
          next_s.last_addr = i_ret_target;
        end else begin
          nm[1] = mk(pftm_pkg::TC_DIRECT, '0, sum[7:0], '0);
        end
      end else if (is_ind) begin
        nv[1]            = 1'b1;
        next_s.cnt       = '0;
        next_s.nosync    = s.nosync + 1'b1;
        // cause arrives already classified by the pipeline
        nm[1] = mk(pftm_pkg::TC_INDIRECT, i_ret_target ^ s.last_addr,
                   sum[7:0], cause_evt(i_ret_cause));
        next_s.last_addr = i_ret_target;
      end
    end

    // level edges only advance while the pending list is empty
    if (!s.stall) begin
      if (rose(i_debug_mode, s.dbg_q) && i_trace_mode_en) begin
        corr = 1'b1;
        evc  = pftm_pkg::EVC_DEBUG;
      end else if (fell(i_trace_mode_en, s.trc_q) && !i_debug_mode) begin
        corr = 1'b1;
        evc  = pftm_pkg::EVC_TRACE_OFF;
      end else if (rose(i_sleep_mode, s.slp_q) && act) begin
        corr = 1'b1;
        evc  = pftm_pkg::EVC_SLEEP;
      end else if (i_bkpt_hit && s.first_after_dbg && act) begin
        corr = 1'b1;
        evc  = pftm_pkg::EVC_DEBUG;
        next_s.first_after_dbg = 1'b0;
      end
      if (corr) begin
        nv[2]      = 1'b1;
        nm[2]      = mk(pftm_pkg::TC_CORR, '0, next_s.cnt, evc);
        next_s.cnt = '0;
      end
      if (fell(i_debug_mode, s.dbg_q)) begin
        next_s.first_after_dbg = 1'b1;
      end
      next_s.dbg_q = i_debug_mode;
      next_s.trc_q = i_trace_mode_en;
      next_s.slp_q = i_sleep_mode;
    end
    // outside the stall guard so that a one-cycle sync request is never lost;
    // a new sync cause wins over the clear by the sync message
    if (sync_set) begin
      next_s.sync_pend = 1'b1;
    end else if (take && s.sync_pend) begin
      next_s.sync_pend = 1'b0;
    end

    // append in execution order
    for (int i = 0; i < pftm_pkg::PEND_DEPTH; i++) begin
      if (nv[i]) begin
        next_s.pend[next_s.pend_cnt] = nm[i];
        next_s.pend_cnt              = next_s.pend_cnt + 1'b1;
      end
    end
    // stall the pipeline until every pending message has been handed over
    next_s.stall = (next_s.pend_cnt != '0);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  pftm_fifo #(
    .WIDTH (MSG_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (s.pend_cnt != '0),
    .i_in_data   (s.pend[0]),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (i_msg_ready)
  );

  assign fifo_msg        = pftm_pkg::pftm_msg_t'(fifo_out_data);
  assign o_stall         = s.stall;
  assign o_msg_valid     = fifo_out_valid;
  assign o_msg_tcode     = fifo_msg.tcode;
  assign o_msg_addr      = fifo_msg.addr;
  assign o_msg_addr_bits = fifo_msg.abits;
  assign o_msg_cnt       = fifo_msg.cnt;
  assign o_msg_evt       = fifo_msg.evt;

endmodule

// ### shared/pftm_pkg.sv
// constants and types shared by the program flow trace message block
package pftm_pkg;

  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned TCODE_W    = 6;
  localparam int unsigned EVT_W      = 4;
  localparam int unsigned ABITS_W    = 6;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned PEND_DEPTH = 3;

  // message type codes
  localparam logic [5:0] TC_DIRECT     = 6'h03;
  localparam logic [5:0] TC_INDIRECT   = 6'h04;
  localparam logic [5:0] TC_SYNC       = 6'h09;
  localparam logic [5:0] TC_DIR_SYNC   = 6'h0b;
  localparam logic [5:0] TC_IND_SYNC   = 6'h0c;
  localparam logic [5:0] TC_RES_FULL   = 6'h1b;
  localparam logic [5:0] TC_DIR_TARGET = 6'h39;
  localparam logic [5:0] TC_CORR       = 6'h21;

  // indirect branch causes
  localparam logic [1:0] EVT_EXCEPTION = 2'h3;
  localparam logic [1:0] EVT_CALL      = 2'h2;
  localparam logic [1:0] EVT_REGISTER  = 2'h1;
  localparam logic [1:0] EVT_RETURN    = 2'h0;

  // correlation event codes and resource code
  localparam logic [3:0] EVC_DEBUG     = 4'h0;
  localparam logic [3:0] EVC_TRACE_OFF = 4'h4;
  localparam logic [3:0] EVC_SLEEP     = 4'h5;
  localparam logic [3:0] RCODE_COUNTER = 4'h0;

  // byte sizes of retired instructions and counter limits
  localparam logic [8:0] SIZE_COMPACT  = 9'h002;
  localparam logic [8:0] SIZE_EXTENDED = 9'h004;
  localparam logic [8:0] CNT_MAX       = 9'h0ff;
  localparam logic [7:0] NOSYNC_LIMIT  = 8'hff;

  typedef enum logic [1:0] {
    PFTM_KIND_SEQ      = 2'b00,
    PFTM_KIND_DIRECT   = 2'b01,
    PFTM_KIND_INDIRECT = 2'b10
  } pftm_kind_t;

  typedef struct packed {
    logic [5:0]  tcode;
    logic [31:0] addr;
    logic [5:0]  abits;
    logic [7:0]  cnt;
    logic [3:0]  evt;
  } pftm_msg_t;

endpackage

// ### verif/pftm_sink.sv
// debug tool model draining trace messages, prompt or with back-pressure
`timescale 1ns/1ps
module pftm_sink (
  input  logic i_clk,
  input  logic i_rst_n,
  input  logic i_hold,
  input  logic i_slow,
  output logic o_ready = 1'h0
);
  logic [7:0] lf = 8'h5a;
  always @(posedge i_clk) begin
    lf      <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    o_ready <= i_rst_n && !i_hold && (!i_slow || lf[0]);
  end
endmodule

// ### verif/pftm_trace_asserts.sv
// port-level checks for the trace message block
`timescale 1ns/1ps
module pftm_trace_asserts (
  input logic        i_clk,
  input logic        i_rst_n,
  input logic        i_trace_mode_en,
  input logic        i_debug_mode,
  input logic        i_ret_valid,
  input logic [1:0]  i_ret_kind,
  input logic        o_stall,
  input logic        o_msg_valid,
  input logic        i_msg_ready,
  input logic [5:0]  o_msg_tcode,
  input logic [31:0] o_msg_addr,
  input logic [5:0]  o_msg_addr_bits,
  input logic [7:0]  o_msg_cnt,
  input logic [3:0]  o_msg_evt
);
  logic [5:0] nb;
  logic       tk;
  logic       mv;
  assign tk = i_ret_valid && !o_stall && i_trace_mode_en && !i_debug_mode;
  assign mv = o_msg_valid;
  // length of the address once leading zeros are stripped
  always_comb begin
    nb = 6'h00;
    for (int b = 0; b < 32; b++) begin
      if (o_msg_addr[b]) begin
        nb = 6'(b + 1);
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_HOLD: assert property (mv && !i_msg_ready |=> mv && $stable(o_msg_tcode)
    && $stable({o_msg_addr, o_msg_cnt, o_msg_evt})) else $error("fields moved");
  AST_CODE: assert property (mv |-> o_msg_tcode inside
    {6'h03, 6'h04, 6'h09, 6'h0b, 6'h0c, 6'h1b, 6'h39, 6'h21}) else $error("bad code");
  AST_BITS: assert property (mv |-> o_msg_addr_bits == nb)
    else $error("bad address length");
  AST_EVEN: assert property (mv |-> !o_msg_cnt[0]) else $error("odd count");
  AST_DIR: assert property (mv && o_msg_tcode == 6'h03 |-> o_msg_addr == 32'h0000_0000
    && o_msg_evt == 4'h0) else $error("direct fields");
  AST_CAUSE: assert property (mv && o_msg_tcode inside {6'h04, 6'h0c}
    |-> o_msg_evt < 4'h4) else $error("cause width");
  AST_FULL: assert property (mv && o_msg_tcode == 6'h1b |-> o_msg_cnt > 8'hfb)
    else $error("early overflow");
  AST_CORR: assert property (mv && o_msg_tcode == 6'h21
    |-> o_msg_evt inside {4'h0, 4'h4, 4'h5}) else $error("bad event");
  AST_BRSTALL: assert property (tk && i_ret_kind inside {2'h1, 2'h2} |=> o_stall)
    else $error("branch left no message");
  cover property (mv && i_msg_ready && o_msg_tcode == 6'h1b);
  cover property (mv && i_msg_ready && o_msg_tcode == 6'h0c);
  cover property (mv && i_msg_ready && o_msg_tcode == 6'h21 && o_msg_evt == 4'h0);
  cover property ((o_stall && !i_msg_ready) [*8]);
endmodule

bind pftm_trace pftm_trace_asserts u_asserts (.*);

// ### verif/pftm_trace_tb.sv
// self-checking bench for the trace message block
`timescale 1ns/1ps
module pftm_trace_tb;
  logic        i_clk = '0, i_rst_n = '0, i_trace_mode_en = '1, i_sleep_mode = '0;
  logic        i_target_address_trace_enable = '0, i_debug_mode = '0, i_sync_req = '0;
  logic        i_bkpt_hit = '0, i_ret_valid = '0, i_ret_ext = '0, hold = '0, slow = '0;
  logic        o_stall, o_msg_valid, i_msg_ready;
  logic [1:0]  i_ret_kind = '0, i_ret_cause = '0;
  logic [31:0] i_ret_pc = '0, i_ret_target = '0, o_msg_addr, s = 32'h0000_0056, rf;
  logic [5:0]  o_msg_tcode, o_msg_addr_bits;
  logic [7:0]  o_msg_cnt;
  logic [3:0]  o_msg_evt;
  pftm_pkg::pftm_msg_t q[$], got, exp_m;
  int          cnt, err_count, checked;
  bit          syn;
  always #2.5 i_clk = ~i_clk;
  pftm_trace #(.FIFO_DEPTH(4)) dut_u (.*);
  pftm_sink sink_u (.i_clk, .i_rst_n, .i_hold(hold), .i_slow(slow), .o_ready(i_msg_ready));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic void push(logic [5:0] tc, logic [31:0] ad, int ct, logic [3:0] ev);
    logic [5:0] nb;
    nb = '0;
    for (int b = 0; b < 32; b++) if (ad[b]) nb = 6'(b + 1);
    q.push_back({tc, ad, nb, ct[7:0], ev});
    cnt = 0;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // xe: 0 compact, 1 extended, 2 random size
  task automatic ret(logic [1:0] k, logic [1:0] c, int xe);
    int n, w;
    logic [31:0] pc, tg;
    logic x, br;
    pc = rnd();
    tg = rnd();
    x = (xe > 1) ? tg[3] : xe[0];
    br = k inside {2'h1, 2'h2};
    n = (k == 2'h2) ? 0 : (x ? 4 : 2);
    @(posedge i_clk);
    i_ret_valid <= 1'h1;
    i_ret_kind <= k;
    i_ret_cause <= c;
    i_ret_ext <= x;
    i_ret_pc <= pc;
    i_ret_target <= tg;
    w = 0;
    // o_stall read before this edge's updates land: the value the design samples
    do begin
      @(posedge i_clk);
      w++;
    end while (o_stall !== 1'h0 && w < 200);
    i_ret_valid <= 1'h0;
    if (w == 200) begin
      err_count++;
      $display("Error stall exp 0 got 1");
      stop_test();
    end
    if (cnt + n > 255) push(6'h1b, '0, cnt, 4'h0);
    cnt += n;
    if (syn && k == 2'h1) push(6'h0b, tg, cnt, 4'h0);
    else if (syn && k == 2'h2) push(6'h0c, tg, cnt, {2'h0, c});
    else if (syn) push(6'h09, pc, cnt - n, 4'h0);
    else if (k == 2'h1 && i_target_address_trace_enable) push(6'h39, tg ^ rf, cnt, 4'h0);
    else if (k == 2'h1) push(6'h03, '0, cnt, 4'h0);
    else if (k == 2'h2) push(6'h04, tg ^ rf, cnt, {2'h0, c});
    if (syn && !br) cnt = n;
    if (syn) rf = br ? tg : pc;
    else if (k == 2'h2 || (k == 2'h1 && i_target_address_trace_enable)) rf = tg;
    syn = 0;
  endtask
  always @(posedge i_clk) begin
    if (i_rst_n && o_msg_valid === 1'h1 && i_msg_ready === 1'h1) begin
      got = {o_msg_tcode, o_msg_addr, o_msg_addr_bits, o_msg_cnt, o_msg_evt};
      exp_m = (q.size() > 0) ? q.pop_front() : '1;
      checked++;
      if (got !== exp_m) begin
        err_count++;
        $display("Error msg exp %h got %h", exp_m, got);
      end
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    syn = 1;
    cnt = 0;
    ret(2'h1, 2'h0, 0);
    for (int i = 0; i < 10; i++) ret({2{s[7]}}, 2'h3, 2);
    ret(2'h1, 2'h0, 2);
    for (int c = 0; c < 4; c++) begin
      repeat (3) ret(2'h0, 2'h2, 2);
      ret(2'h2, 2'(c), 2);
    end
    @(posedge i_clk) i_target_address_trace_enable <= 1'h1;
    ret(2'h1, 2'h0, 1);
    @(posedge i_clk) i_target_address_trace_enable <= 1'h0;
    slow <= 1'h1;
    repeat (66) ret(2'h0, 2'h0, 1);
    ret(2'h1, 2'h0, 0);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk) i_sync_req <= 1'h1;
      @(posedge i_clk) i_sync_req <= 1'h0;
      syn = 1;
      ret(2'(k), 2'h1, 2);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk) i_debug_mode <= 1'h1;
      push(6'h21, '0, cnt, 4'h0);
      // retires offered in debug must be ignored and not counted
      @(posedge i_clk) i_ret_valid <= 1'h1;
      repeat (3) @(posedge i_clk);
      i_ret_valid <= 1'h0;
      @(posedge i_clk) i_debug_mode <= 1'h0;
      // breakpoint on the first instruction after the second exit
      i_bkpt_hit <= (k > 0);
      syn = 1;
      ret(2'(1 - k), 2'h0, 2);
      i_bkpt_hit <= 1'h0;
      if (k > 0) push(6'h21, '0, cnt, 4'h0);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk) if (k > 0) i_sleep_mode <= 1'h1; else i_trace_mode_en <= 1'h0;
      push(6'h21, '0, cnt, (k > 0) ? 4'h5 : 4'h4);
      repeat (4) @(posedge i_clk);
      i_sleep_mode <= 1'h0;
      i_trace_mode_en <= 1'h1;
      syn = 1;
      ret(2'h0, 2'h0, 2);
    end
    @(posedge i_clk) hold <= 1'h1;
    fork
      repeat (10) ret(2'h1, 2'h0, 2);
      begin
        repeat (60) @(posedge i_clk);
        checked++;
        if (o_stall !== 1'h1) begin
          err_count++;
          $display("Error stall exp 1 got %h", o_stall);
        end
        hold <= 1'h0;
      end
    join
    for (int w = 0; w < 300 && q.size() > 0; w++) @(posedge i_clk);
    if (q.size() > 0) begin
      err_count++;
      $display("Error queue exp 0 got %0d", q.size());
    end
    stop_test();
  end
endmodule
